/* rtl/status_irq_regs.svh */
`ifndef STATUS_IRQ_REGS_SVH
`define STATUS_IRQ_REGS_SVH
`define STS_NUM_SRC 8
`define STS_SRC_RST 8'h00
`define STS_IE_RST 8'h00
`define STS_MODE_MANUAL 2'h0
`define STS_MODE_SHORT_HOLD 2'h1
`define STS_MODE_AUTO 2'h2
`define STS_MODE_AUTO_HOLD 2'h3
`endif

/* rtl/status_irq_pkg.sv */
package status_irq_pkg;
    typedef enum logic [1:0] {
        sel_manual = 2'b00,
        sel_short_hold = 2'b01,
        sel_auto = 2'b10,
        sel_auto_hold = 2'b11
    } sel_mode_t;

    // Source order: bits 3..0 inputs, 4 pll1, 5 pll2, 6 holdover, 7 ref
    typedef struct packed {
        logic ref_ok;
        logic not_hold;
        logic pll2_lock;
        logic pll1_lock;
        logic [3:0] input_ok;
    } src_vec_t;

    typedef struct packed {
        logic [7:0] sticky;
    } sticky_state_t;

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic vco_s1;
        logic vco_s2;
        logic [1:0] sel_s1;
        logic [1:0] sel_s2;
        logic hold_s1;
        logic hold_s2;
        logic lock_out;
        logic irq_n;
    } top_state_t;
endpackage : status_irq_pkg

/* rtl/sticky_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "status_irq_regs.svh"
module sticky_bank
    import status_irq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] live_ok,
    input wire logic [7:0] clear_ones,
    input wire logic [7:0] irq_enable,
    output logic [7:0] sticky_ok,
    output logic irq_any
);
    sticky_state_t s_q;
    sticky_state_t s_d;

    // Sticky bits hold the fault (active-high, unlike the live bit); a set
    // beats a write-one clear in the same cycle.
    always_comb begin
        s_d = s_q;
        for (int i = 0; i < 8; i++) begin
            if (!live_ok[i]) begin
                s_d.sticky[i] = 1'b1;
            end else if (clear_ones[i]) begin
                s_d.sticky[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= sticky_state_t'(`STS_SRC_RST);
        end else begin
            s_q <= s_d;
        end
    end

    assign sticky_ok = ~s_q.sticky;
    assign irq_any = |(s_q.sticky & irq_enable);

    property p_fault_sets;
        @(posedge mclk) disable iff (rst)
            !live_ok[0] |=> s_q.sticky[0];
    endproperty
    a_fault_sets: assert property (p_fault_sets)
        else $error("sticky not set by fault");

    property p_hold_sticky;
        @(posedge mclk) disable iff (rst)
            s_q.sticky[4] && !clear_ones[4] |=> s_q.sticky[4];
    endproperty
    a_hold_sticky: assert property (p_hold_sticky)
        else $error("sticky dropped without clear");

    property p_clear_works;
        @(posedge mclk) disable iff (rst)
            clear_ones[5] && live_ok[5] |=> !s_q.sticky[5];
    endproperty
    a_clear_works: assert property (p_clear_works)
        else $error("clear ignored");

    property p_mask;
        @(posedge mclk) disable iff (rst)
            irq_enable == 8'h00 |-> !irq_any;
    endproperty
    a_mask: assert property (p_mask)
        else $error("masked irq asserted");
endmodule : sticky_bank
`default_nettype wire

/* rtl/status_interrupt_lock_report.sv */
// Functional notes
// - Live status bits are read-only and show the present condition.
// - Sticky bits stay set until a one is written; zero leaves them.
// - Clear takes only once the condition is gone; else it sets again.
// - Each sticky bit is gated by its own enable; zero masks it.
// - Interrupt stays asserted while any enabled sticky bit is set.
// - Four inputs: one active, zero on signal loss; sticky and enable.
// - Both PLLs report locked one, loss of lock zero, sticky and enable.
// - Holdover reports one when not in holdover, with sticky and enable.
// - VCO calibration status is live only: one while still pending.
// - Lock output high only when both PLLs are locked, or the second alone when the first is dropped.
// - Lock-report mask drops first PLL from the lock output.
// - First PLL bypass also drops its lock from the lock output.
// - Manual and short holdover: reference status follows chosen input.
// - Automatic modes: zero if no input valid; auto-holdover mode is also zero while in holdover.
`timescale 1ns/1ps
`default_nettype none
`include "status_irq_regs.svh"
module status_interrupt_lock_report
    import status_irq_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] signal_absent,
    input wire logic pll1_lock_raw,
    input wire logic pll2_lock_raw,
    input wire logic in_holdover,
    input wire logic vco_cal_done,
    input wire logic [1:0] active_input,
    input wire sel_mode_t sel_mode,
    input wire logic [1:0] input_select,
    input wire logic pll1_lock_report_mask,
    input wire logic pll1_bypass,
    input wire logic [7:0] sticky_clear,
    input wire logic [7:0] irq_enable,
    output logic [3:0] input_live_status,
    output logic [3:0] input_sticky_status,
    output logic pll1_locked_live,
    output logic pll1_locked_sticky,
    output logic pll2_locked_live,
    output logic pll2_locked_sticky,
    output logic not_holdover_live,
    output logic not_holdover_sticky,
    output logic vco_cal_pending,
    output logic [1:0] selected_input_code,
    output logic reference_valid_live,
    output logic reference_valid_sticky,
    output logic lock_out,
    output logic irq_out_n
);
    top_state_t s_q;
    top_state_t s_d;
    src_vec_t live;
    src_vec_t sticky;
    logic irq_any;
    logic ref_ok;
    logic pll1_counts;

    // Status arrives from the analog side, so every level is resynchronised
    always_comb begin
        s_d = s_q;
        s_d.sync1 = {2'b00, pll2_lock_raw, pll1_lock_raw, ~signal_absent};
        s_d.sync2 = s_q.sync1;
        s_d.vco_s1 = ~vco_cal_done;
        s_d.vco_s2 = s_q.vco_s1;
        s_d.sel_s1 = active_input;
        s_d.sel_s2 = s_q.sel_s1;
        s_d.hold_s1 = in_holdover;
        s_d.hold_s2 = s_q.hold_s1;
        // Bypass or mask removes the first PLL from the lock report
        pll1_counts = !pll1_lock_report_mask
            && !pll1_bypass;
        s_d.lock_out = s_q.sync2[5]
            && (s_q.sync2[4] || !pll1_counts);
        s_d.irq_n = !irq_any;
    end

    // Reference status depends on the selection mode
    always_comb begin
        case (sel_mode)
            sel_manual, sel_short_hold:
                ref_ok = s_q.sync2[input_select];
            sel_auto:
                ref_ok = |s_q.sync2[3:0];
            sel_auto_hold:
                ref_ok = |s_q.sync2[3:0] && !s_q.hold_s2;
            default:
                ref_ok = 1'b0;
        endcase
    end

    always_comb begin
        live.input_ok = s_q.sync2[3:0];
        live.pll1_lock = s_q.sync2[4];
        live.pll2_lock = s_q.sync2[5];
        live.not_hold = !s_q.hold_s2;
        live.ref_ok = ref_ok;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.irq_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    sticky_bank u_sticky (
        .mclk(mclk),
        .rst(rst),
        .live_ok(live),
        .clear_ones(sticky_clear),
        .irq_enable(irq_enable),
        .sticky_ok(sticky),
        .irq_any(irq_any)
    );

    // Live bits carry no history; they follow the synchronised condition
    assign input_live_status = live.input_ok;
    assign input_sticky_status = sticky.input_ok;
    assign pll1_locked_live = live.pll1_lock;
    assign pll1_locked_sticky = sticky.pll1_lock;
    assign pll2_locked_live = live.pll2_lock;
    assign pll2_locked_sticky = sticky.pll2_lock;
    assign not_holdover_live = live.not_hold;
    assign not_holdover_sticky = sticky.not_hold;
    assign vco_cal_pending = s_q.vco_s2;
    assign selected_input_code = s_q.sel_s2;
    assign reference_valid_live = live.ref_ok;
    assign reference_valid_sticky = sticky.ref_ok;
    assign lock_out = s_q.lock_out;
    assign irq_out_n = s_q.irq_n;

    property p_lock_both;
        @(posedge mclk) disable iff (rst)
            !s_q.sync2[5] |=> !s_q.lock_out;
    endproperty
    a_lock_both: assert property (p_lock_both)
        else $error("lock high with pll2 unlocked");

    property p_lock_pll1;
        @(posedge mclk) disable iff (rst)
            !s_q.sync2[4] && !pll1_lock_report_mask && !pll1_bypass
            |=> !s_q.lock_out;
    endproperty
    a_lock_pll1: assert property (p_lock_pll1)
        else $error("lock high with pll1 unlocked");

    property p_lock_masked;
        @(posedge mclk) disable iff (rst)
            s_q.sync2[5] && (pll1_lock_report_mask || pll1_bypass)
            |=> s_q.lock_out;
    endproperty
    a_lock_masked: assert property (p_lock_masked)
        else $error("masked pll1 still affects lock");

    property p_irq_follow;
        @(posedge mclk) disable iff (rst)
            irq_any |=> !irq_out_n;
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("irq not asserted");

    sequence s_no_src;
        !irq_any ##1 !irq_any;
    endsequence
    property p_irq_release;
        @(posedge mclk) disable iff (rst)
            s_no_src |-> irq_out_n;
    endproperty
    a_irq_release: assert property (p_irq_release)
        else $error("irq not released");

    property p_ref_auto;
        @(posedge mclk) disable iff (rst)
            sel_mode == sel_auto && s_q.sync2[3:0] == 4'h0
            |-> !reference_valid_live;
    endproperty
    a_ref_auto: assert property (p_ref_auto)
        else $error("reference valid with no input");

    property p_input_live;
        @(posedge mclk) disable iff (rst)
            signal_absent[2] ##2 1'b1 |-> !input_live_status[2];
    endproperty
    a_input_live: assert property (p_input_live)
        else $error("input live wrong");

    property p_vco_live;
        @(posedge mclk) disable iff (rst)
            vco_cal_done ##2 1'b1 |-> !vco_cal_pending;
    endproperty
    a_vco_live: assert property (p_vco_live)
        else $error("calibration pending after done");

    property p_sel_live;
        @(posedge mclk) disable iff (rst)
            active_input == 2'h3 ##2 1'b1 |-> selected_input_code == 2'h3;
    endproperty
    a_sel_live: assert property (p_sel_live)
        else $error("selected input code wrong");

    property p_ref_manual;
        @(posedge mclk) disable iff (rst)
            (sel_mode == sel_manual || sel_mode == sel_short_hold)
            && !s_q.sync2[input_select] |-> !reference_valid_live;
    endproperty
    a_ref_manual: assert property (p_ref_manual)
        else $error("reference valid with chosen input lost");

    property p_ref_hold;
        @(posedge mclk) disable iff (rst)
            sel_mode == sel_auto_hold && s_q.hold_s2
            |-> !reference_valid_live;
    endproperty
    a_ref_hold: assert property (p_ref_hold)
        else $error("reference valid in holdover");

    property p_lock_bypass;
        @(posedge mclk) disable iff (rst)
            s_q.sync2[5] && !s_q.sync2[4] && pll1_bypass |=> lock_out;
    endproperty
    a_lock_bypass: assert property (p_lock_bypass)
        else $error("bypassed pll1 still affects lock");

    // Pin to sticky takes three edges: two sync stages, then the latch
    sequence s_pll2_drop;
        pll2_lock_raw == 1'b0 ##2 1'b1;
    endsequence
    property p_pll2_sticky;
        @(posedge mclk) disable iff (rst)
            s_pll2_drop |=> !pll2_locked_sticky;
    endproperty
    a_pll2_sticky: assert property (p_pll2_sticky)
        else $error("pll2 loss not latched");
endmodule : status_interrupt_lock_report
`default_nettype wire

/* test/tb_status_interrupt_lock_report.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_status_interrupt_lock_report
    import status_irq_pkg::*;
();
    logic mclk, rst, pll1_lock_raw, pll2_lock_raw, in_holdover, vco_cal_done;
    logic [3:0] signal_absent, input_live_status, input_sticky_status;
    logic [1:0] active_input, input_select, selected_input_code;
    sel_mode_t sel_mode;
    logic pll1_lock_report_mask, pll1_bypass;
    logic [7:0] sticky_clear, irq_enable, exp_sticky;
    logic pll1_locked_live, pll1_locked_sticky, pll2_locked_live;
    logic pll2_locked_sticky, not_holdover_live, not_holdover_sticky;
    logic vco_cal_pending, reference_valid_live, reference_valid_sticky;
    logic lock_out, irq_out_n;
    int n_mismatch, tests_run;

    status_interrupt_lock_report dut (.mclk(mclk), .rst(rst),
        .signal_absent(signal_absent), .pll1_lock_raw(pll1_lock_raw),
        .pll2_lock_raw(pll2_lock_raw), .in_holdover(in_holdover),
        .vco_cal_done(vco_cal_done), .active_input(active_input),
        .sel_mode(sel_mode), .input_select(input_select),
        .pll1_lock_report_mask(pll1_lock_report_mask),
        .pll1_bypass(pll1_bypass), .sticky_clear(sticky_clear),
        .irq_enable(irq_enable), .input_live_status(input_live_status),
        .input_sticky_status(input_sticky_status),
        .pll1_locked_live(pll1_locked_live),
        .pll1_locked_sticky(pll1_locked_sticky),
        .pll2_locked_live(pll2_locked_live),
        .pll2_locked_sticky(pll2_locked_sticky),
        .not_holdover_live(not_holdover_live),
        .not_holdover_sticky(not_holdover_sticky),
        .vco_cal_pending(vco_cal_pending),
        .selected_input_code(selected_input_code),
        .reference_valid_live(reference_valid_live),
        .reference_valid_sticky(reference_valid_sticky),
        .lock_out(lock_out), .irq_out_n(irq_out_n));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Inputs always move 2 ns after the edge, away from sampling
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : step

    task automatic pulse_clear(input logic [7:0] m);
        sticky_clear = m;
        step(1);
        sticky_clear = 8'h00;
    endtask : pulse_clear

    function automatic logic ref_exp();
        case (sel_mode)
            sel_manual, sel_short_hold: return !signal_absent[input_select];
            sel_auto: return signal_absent != 4'hf;
            default: return (signal_absent != 4'hf) && !in_holdover;
        endcase
    endfunction : ref_exp

    function automatic logic [7:0] good_vec();
        return {ref_exp(), ~in_holdover, pll2_lock_raw, pll1_lock_raw,
                ~signal_absent};
    endfunction : good_vec

    function automatic logic lock_exp();
        return pll2_lock_raw & (pll1_lock_raw | pll1_lock_report_mask |
                                pll1_bypass);
    endfunction : lock_exp

    task automatic check_all();
        logic [7:0] g;
        logic [7:0] s;
        g = good_vec();
        s = {reference_valid_sticky, not_holdover_sticky, pll2_locked_sticky,
             pll1_locked_sticky, input_sticky_status};
        check("inputs", {4'h0, input_live_status},
              {4'h0, g[3:0]});
        check("pll1", {7'h0, pll1_locked_live}, {7'h0, g[4]});
        check("pll2", {7'h0, pll2_locked_live}, {7'h0, g[5]});
        check("hold", {7'h0, not_holdover_live}, {7'h0, g[6]});
        check("vco", {7'h0, vco_cal_pending},
              {7'h0, ~vco_cal_done});
        check("sel", {6'h0, selected_input_code},
              {6'h0, active_input});
        check("ref", {7'h0, reference_valid_live},
              {7'h0, g[7]});
        check("lock", {7'h0, lock_out},
              {7'h0, lock_exp()});
        check("sticky", s, exp_sticky);
        check("irq", {7'h0, irq_out_n},
              {7'h0, ~|(~exp_sticky & irq_enable)});
    endtask : check_all

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    initial begin
        n_mismatch = 0;
        tests_run = 0;
        rst = 1'b1;
        signal_absent = 4'h0;
        {pll1_lock_raw, pll2_lock_raw, vco_cal_done} = 3'b111;
        {in_holdover, pll1_lock_report_mask, pll1_bypass} = 3'b000;
        active_input = 2'h0;
        input_select = 2'h0;
        sel_mode = sel_manual;
        sticky_clear = 8'h00;
        irq_enable = 8'h00;
        void'($urandom(32'hc692_84eb));
        step(10);
        check("rst sticky", {reference_valid_sticky, not_holdover_sticky,
              pll2_locked_sticky, pll1_locked_sticky, input_sticky_status},
              8'hff);
        check("rst irq", {7'h0, irq_out_n}, 8'h01);
        check("rst lock", {7'h0, lock_out}, 8'h00);
        rst = 1'b0;
        // Syncs come out of reset low, so faults latch; clear them first
        step(6);
        pulse_clear(8'hff);
        step(4);
        exp_sticky = 8'hff;
        irq_enable = 8'h02;
        signal_absent = 4'h2;
        step(6);
        signal_absent = 4'h0;
        step(6);
        exp_sticky = 8'hfd;
        check_all();
        pulse_clear(8'hfd);
        step(4);
        check_all();
        irq_enable = 8'hfd;
        step(3);
        check_all();
        signal_absent = 4'h2;
        step(6);
        pulse_clear(8'h02);
        step(4);
        check_all();
        signal_absent = 4'h0;
        irq_enable = 8'h02;
        step(6);
        pulse_clear(8'h02);
        step(4);
        exp_sticky = 8'hff;
        check_all();
        for (int i = 0; i < 64; i++) begin
            signal_absent = 4'($urandom);
            {pll1_lock_raw, pll2_lock_raw, in_holdover} = 3'($urandom);
            {vco_cal_done, pll1_lock_report_mask, pll1_bypass} = 3'($urandom);
            active_input = 2'($urandom);
            input_select = 2'($urandom);
            sel_mode = sel_mode_t'(i[1:0]);
            irq_enable = 8'($urandom);
            step(6);
            pulse_clear(8'hff);
            step(4);
            exp_sticky = good_vec();
            check_all();
        end
        // Second reset mid-run, with random inputs and enables still set
        rst = 1'b1;
        step(2);
        check("rst2 sticky", {reference_valid_sticky, not_holdover_sticky,
              pll2_locked_sticky, pll1_locked_sticky, input_sticky_status},
              8'hff);
        check("rst2 irq", {7'h0, irq_out_n}, 8'h01);
        check("rst2 lock", {7'h0, lock_out}, 8'h00);
        rst = 1'b0;
        step(6);
        pulse_clear(8'hff);
        step(4);
        exp_sticky = good_vec();
        check_all();
        print_verdict();
    end
endmodule : tb_status_interrupt_lock_report
`default_nettype wire
